//--- design/hcar_pkg.sv
// constants and carrier types of the host cycle address router
package hcar_pkg;
	// ----------------------------------------
	// register offsets
	// ----------------------------------------
	localparam logic [7:0] OFS_BRIDGE_CONTROL = 8'h3e;
	localparam logic [7:0] OFS_SEC_COMMAND = 8'h04;
	localparam logic [7:0] OFS_IO_BASE = 8'h1c;
	localparam logic [7:0] OFS_IO_LIMIT = 8'h1d;
	localparam logic [7:0] OFS_MEM_BASE = 8'h20;
	localparam logic [7:0] OFS_MEM_LIMIT = 8'h22;
	localparam logic [7:0] OFS_PF_BASE = 8'h24;
	localparam logic [7:0] OFS_PF_LIMIT = 8'h26;
	localparam logic [7:0] OFS_TOP_DRAM = 8'h60;
	localparam logic [7:0] OFS_HOLE_CTRL = 8'h64;
	localparam logic [7:0] OFS_SEG_READ = 8'h68;
	localparam logic [7:0] OFS_SEG_WRITE = 8'h6c;
	localparam logic [7:0] OFS_STATUS = 8'h70;
	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int BC_VGA_BIT = 3;
	localparam int BC_ISA_BIT = 2;
	localparam int BC_SERR_BIT = 1;
	localparam int BC_PERR_BIT = 0;
	localparam int CMD_SERRE_BIT = 8;
	localparam int HOLE_DOS_BIT = 0;
	localparam int HOLE_MEMWIN_BIT = 1;
	localparam int NUM_SEGMENTS = 13;
	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic [15:0] RST_BRIDGE_CONTROL = 16'h0000;
	localparam logic [15:0] RST_SEC_COMMAND = 16'h0000;
	localparam logic [7:0] RST_IO_BASE = 8'hf0;
	localparam logic [7:0] RST_IO_LIMIT = 8'h00;
	localparam logic [15:0] RST_MEM_BASE = 16'hfff0;
	localparam logic [15:0] RST_MEM_LIMIT = 16'h0000;
	localparam logic [11:0] RST_TOP_DRAM = 12'h000;
	localparam logic [12:0] RST_SEG = 13'h0000;
	// ----------------------------------------
	// address map
	// ----------------------------------------
	localparam logic [31:0] VGA_MEM_LO = 32'h000a0000;
	localparam logic [31:0] VGA_MEM_HI = 32'h000bffff;
	localparam logic [9:0] VGA_IO_A_LO = 10'h3b0;
	localparam logic [9:0] VGA_IO_A_HI = 10'h3bb;
	localparam logic [9:0] VGA_IO_B_LO = 10'h3c0;
	localparam logic [9:0] VGA_IO_B_HI = 10'h3df;
	localparam logic [31:0] DOS_LO_TOP = 32'h0007ffff;
	localparam logic [31:0] DOS_HI_TOP = 32'h0009ffff;
	localparam logic [31:0] EXP_BASE = 32'h000c0000;
	localparam logic [31:0] ONE_MB = 32'h00100000;
	localparam int SEG_SHIFT = 14;
	localparam int SEG_FIRST_BIOS = 12;
	localparam logic [19:0] LOW_ZERO = 20'h00000;
	localparam logic [19:0] LOW_ONES = 20'hfffff;

	typedef enum logic [1:0] {
		TGT_MEMORY,
		TGT_PCI,
		TGT_GRAPHICS,
		TGT_LOCAL
	} hcar_target_t;

	typedef struct packed {
		logic isIo;
		logic isWrite;
		logic [35:0] addr;
	} hcar_cycle_t;

	typedef struct packed {
		hcar_target_t target;
		logic zeroRead;
		logic dropWrite;
	} hcar_route_t;
endpackage

//--- design/hcar_seg_attr.sv
// per-segment read and write enables of the compatibility area
`timescale 1ns/1ps
module hcar_seg_attr
	import hcar_pkg::*;
#(
	parameter int SEGS = NUM_SEGMENTS
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic sys_rst,
	// write side
	input wire logic wrRead,
	input wire logic wrWrite,
	input wire logic [SEGS-1:0] wrData,
	// lookup side
	input wire logic [3:0] segIdx,
	output logic segReadEn,
	output logic segWriteEn,
	output logic [SEGS-1:0] readMask,
	output logic [SEGS-1:0] writeMask
);
	logic [SEGS-1:0] rdEn_q;
	logic [SEGS-1:0] wrEn_q;

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			rdEn_q <= SEGS'(RST_SEG);
		end else if (wrRead) begin
			rdEn_q <= wrData;
		end
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			wrEn_q <= SEGS'(RST_SEG);
		end else if (wrWrite) begin
			wrEn_q <= wrData;
		end
	end

	always_comb begin
		segReadEn = 1'b0;
		segWriteEn = 1'b0;
		if (32'(segIdx) < SEGS) begin
			segReadEn = rdEn_q[segIdx];
			segWriteEn = wrEn_q[segIdx];
		end
	end

	assign readMask = rdEn_q;
	assign writeMask = wrEn_q;
endmodule

//--- design/hcar_router.sv
// host cycle address router: routing decode, error forwarding and control registers
// Contract
// - VGA bit on: memory A0000h-BFFFFh goes to graphics port.
// - VGA bit on: I/O low ten bits 3B0-3BB, 3C0-3DF go graphics; aliases match.
// - VGA forwarding ignores base/limit windows and ISA filtering.
// - VGA bit off: VGA ranges go PCI unless inside a programmed window.
// - ISA filter on: window I/O in last 768 bytes of 1 KB goes PCI.
// - ISA filter off: all I/O inside the I/O window goes graphics.
// - SERR forwarded only when forward bit, secondary SERR enable and input all set.
// - parity always generated on graphics transfers.
// - parity response bit gates graphics parity error report; clear ignores errors.
// - parity bit with secondary SERR enable reports address parity via SERR.
// - accesses at or above 4 GB are claimed and terminated locally.
// - above 4 GB writes discard data, reads return zero.
// - no dual address cycles on PCI or graphics port.
// - memory above top of DRAM, video, holes, memory window go PCI; code sends window hits to graphics unless hole control bit 1 is set.
// - first megabyte split into DOS, option, video, expansion, BIOS regions.
// - thirteen segments with read/write enables; 512-640 KB to DRAM or PCI.
// - decode 4 GB memory space and 64 KB I/O space.
// - memory windows use bits 31:20; base low bits zero, limit ones.
//
// Implementation choices: the strobed register port and the register addresses.
`timescale 1ns/1ps
module hcar_router
	import hcar_pkg::*;
(
	// clock and reset
	input wire logic core_clk,
	input wire logic sys_rst,
	// register port
	input wire logic [7:0] regAddr,
	input wire logic [15:0] regWrData,
	input wire logic regWrite,
	input wire logic regRead,
	output logic [15:0] regRdData,
	// host cycle request
	input wire logic cycValid,
	input wire hcar_cycle_t cycIn,
	output logic routeValid,
	output hcar_route_t routeOut,
	// graphics port data and parity
	input wire logic [31:0] gfxData,
	input wire logic gfxParityIn,
	input wire logic gfxAddrPhase,
	input wire logic gfxDataPhase,
	input wire logic graphics_system_error_in_n,
	output logic gfxParityOut,
	output logic graphics_parity_error_out_n,
	output logic primarySerr_n,
	output logic dualAddrCycleEn
);
	// ----------------------------------------
	// registers
	// ----------------------------------------
	logic [15:0] bridge_control_q;
	logic [15:0] secondary_command_reg_q;
	logic [7:0] io_window_base_q;
	logic [7:0] io_window_limit_q;
	logic [15:0] mem_window_base_q;
	logic [15:0] mem_window_limit_q;
	logic [15:0] prefetch_window_base_q;
	logic [15:0] prefetch_window_limit_q;
	logic [11:0] topDram_q;
	logic [1:0] holeCtrl_q;
	logic [15:0] regRdData_q;
	logic [1:0] lastTarget_q;
	logic [3:0] segIdx;
	logic segReadEn;
	logic segWriteEn;
	logic [NUM_SEGMENTS-1:0] segReadMask;
	logic [NUM_SEGMENTS-1:0] segWriteMask;

	function automatic logic winHit(input logic [31:0] a, input logic [15:0] b, input logic [15:0] l);
		winHit = (a >= {b[15:4], LOW_ZERO}) && (a <= {l[15:4], LOW_ONES});
	endfunction

	function automatic logic inRange10(input logic [9:0] a, input logic [9:0] lo, input logic [9:0] hi);
		inRange10 = (a >= lo) && (a <= hi);
	endfunction

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			bridge_control_q <= RST_BRIDGE_CONTROL;
			secondary_command_reg_q <= RST_SEC_COMMAND;
			io_window_base_q <= RST_IO_BASE;
			io_window_limit_q <= RST_IO_LIMIT;
			mem_window_base_q <= RST_MEM_BASE;
			mem_window_limit_q <= RST_MEM_LIMIT;
			prefetch_window_base_q <= RST_MEM_BASE;
			prefetch_window_limit_q <= RST_MEM_LIMIT;
			topDram_q <= RST_TOP_DRAM;
			holeCtrl_q <= 2'h0;
		end else if (regWrite) begin
			case (regAddr)
				OFS_BRIDGE_CONTROL: bridge_control_q <= {12'h000, regWrData[3:0]};
				OFS_SEC_COMMAND: secondary_command_reg_q <= regWrData;
				OFS_IO_BASE: io_window_base_q <= {regWrData[7:4], 4'h0};
				OFS_IO_LIMIT: io_window_limit_q <= {regWrData[7:4], 4'h0};
				OFS_MEM_BASE: mem_window_base_q <= {regWrData[15:4], 4'h0};
				OFS_MEM_LIMIT: mem_window_limit_q <= {regWrData[15:4], 4'h0};
				OFS_PF_BASE: prefetch_window_base_q <= {regWrData[15:4], 4'h0};
				OFS_PF_LIMIT: prefetch_window_limit_q <= {regWrData[15:4], 4'h0};
				OFS_TOP_DRAM: topDram_q <= regWrData[11:0];
				OFS_HOLE_CTRL: holeCtrl_q <= regWrData[1:0];
				default: begin
				end
			endcase
		end
	end

	// ----------------------------------------
	// segment attributes
	// ----------------------------------------
	hcar_seg_attr #(.SEGS(NUM_SEGMENTS)) hcar_seg_attr_i (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.wrRead(regWrite && regAddr == OFS_SEG_READ),
		.wrWrite(regWrite && regAddr == OFS_SEG_WRITE),
		.wrData(regWrData[NUM_SEGMENTS-1:0]),
		.segIdx(segIdx),
		.segReadEn(segReadEn),
		.segWriteEn(segWriteEn),
		.readMask(segReadMask),
		.writeMask(segWriteMask)
	);

	// ----------------------------------------
	// read port
	// ----------------------------------------
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			regRdData_q <= 16'h0000;
		end else if (regRead) begin
			case (regAddr)
				OFS_BRIDGE_CONTROL: regRdData_q <= bridge_control_q;
				OFS_SEC_COMMAND: regRdData_q <= secondary_command_reg_q;
				OFS_IO_BASE: regRdData_q <= {8'h00, io_window_base_q};
				OFS_IO_LIMIT: regRdData_q <= {8'h00, io_window_limit_q};
				OFS_MEM_BASE: regRdData_q <= mem_window_base_q;
				OFS_MEM_LIMIT: regRdData_q <= mem_window_limit_q;
				OFS_PF_BASE: regRdData_q <= prefetch_window_base_q;
				OFS_PF_LIMIT: regRdData_q <= prefetch_window_limit_q;
				OFS_TOP_DRAM: regRdData_q <= {4'h0, topDram_q};
				OFS_HOLE_CTRL: regRdData_q <= {14'h0000, holeCtrl_q};
				OFS_SEG_READ: regRdData_q <= {3'h0, segReadMask};
				OFS_SEG_WRITE: regRdData_q <= {3'h0, segWriteMask};
				OFS_STATUS: regRdData_q <= {14'h0000, lastTarget_q};
				default: regRdData_q <= 16'h0000;
			endcase
		end else begin
			regRdData_q <= 16'h0000;
		end
	end
	assign regRdData = regRdData_q;

	// ----------------------------------------
	// address decode
	// ----------------------------------------
	logic [31:0] a32;
	logic above4g;
	logic vgaOn;
	logic isaOn;
	logic vgaMem;
	logic vgaIo;
	logic ioWin;
	logic isaAlias;
	logic memWin;
	logic pfWin;
	logic compat;
	logic [3:0] segRaw;
	hcar_target_t tgt;

	assign a32 = cycIn.addr[31:0];
	assign above4g = |cycIn.addr[35:32];
	assign vgaOn = bridge_control_q[BC_VGA_BIT];
	assign isaOn = bridge_control_q[BC_ISA_BIT];
	assign vgaMem = (a32 >= VGA_MEM_LO) && (a32 <= VGA_MEM_HI);
	assign vgaIo = inRange10(a32[9:0], VGA_IO_A_LO, VGA_IO_A_HI)
		|| inRange10(a32[9:0], VGA_IO_B_LO, VGA_IO_B_HI);
	// I/O window uses 4 KB granularity over the 64 KB space
	assign ioWin = (a32[15:12] >= io_window_base_q[7:4]) && (a32[15:12] <= io_window_limit_q[7:4]);
	assign isaAlias = a32[9:8] != 2'b00;
	assign memWin = winHit(a32, mem_window_base_q, mem_window_limit_q);
	assign pfWin = winHit(a32, prefetch_window_base_q, prefetch_window_limit_q);
	assign compat = a32 < ONE_MB;
	assign segRaw = 4'((a32 - EXP_BASE) >> SEG_SHIFT);
	// the system bios area is one segment: every 16 KB step above it folds onto the last index
	assign segIdx = (a32 >= EXP_BASE && compat)
		? ((segRaw > 4'(SEG_FIRST_BIOS)) ? 4'(SEG_FIRST_BIOS) : segRaw) : 4'hf;

	always_comb begin
		tgt = TGT_PCI;
		if (above4g) begin
			tgt = TGT_LOCAL;
		end else if (cycIn.isIo) begin
			if (vgaOn && vgaIo) begin
				tgt = TGT_GRAPHICS;
			end else if (ioWin && !(isaOn && isaAlias)) begin
				tgt = TGT_GRAPHICS;
			end else begin
				tgt = TGT_PCI;
			end
		end else if (vgaMem) begin
			tgt = (vgaOn || memWin || pfWin) ? TGT_GRAPHICS : TGT_PCI;
		end else if (memWin || pfWin) begin
			tgt = holeCtrl_q[HOLE_MEMWIN_BIT] ? TGT_PCI : TGT_GRAPHICS;
		end else if (a32 <= DOS_LO_TOP) begin
			tgt = TGT_MEMORY;
		end else if (a32 <= DOS_HI_TOP) begin
			tgt = holeCtrl_q[HOLE_DOS_BIT] ? TGT_PCI : TGT_MEMORY;
		end else if (compat) begin
			if (cycIn.isWrite) begin
				tgt = segWriteEn ? TGT_MEMORY : TGT_PCI;
			end else begin
				tgt = segReadEn ? TGT_MEMORY : TGT_PCI;
			end
		end else if (a32[31:20] > topDram_q) begin
			tgt = TGT_PCI;
		end else begin
			tgt = TGT_MEMORY;
		end
	end

	// ----------------------------------------
	// route output
	// ----------------------------------------
	logic routeValid_q;
	hcar_route_t route_q;

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			routeValid_q <= 1'b0;
			route_q <= '{target: TGT_PCI, zeroRead: 1'b0, dropWrite: 1'b0};
		end else begin
			routeValid_q <= cycValid;
			if (cycValid) begin
				route_q.target <= tgt;
				route_q.zeroRead <= above4g && !cycIn.isWrite;
				route_q.dropWrite <= above4g && cycIn.isWrite;
			end
		end
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			lastTarget_q <= 2'h1;
		end else if (cycValid) begin
			lastTarget_q <= 2'(tgt);
		end
	end

	assign routeValid = routeValid_q;
	assign routeOut = route_q;

	// ----------------------------------------
	// parity and system error
	// ----------------------------------------
	logic [1:0] gserrSync_q;
	logic [1:0] parSync_q;
	logic perr_n_q;
	logic serr_n_q;
	logic genPar_q;
	logic dac_q;
	logic parErr;
	logic perrOn;
	logic serreOn;

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			gserrSync_q <= 2'b11;
		end else begin
			gserrSync_q <= {gserrSync_q[0], graphics_system_error_in_n};
		end
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			parSync_q <= 2'b00;
		end else begin
			parSync_q <= {parSync_q[0], gfxParityIn};
		end
	end

	assign perrOn = bridge_control_q[BC_PERR_BIT];
	assign serreOn = secondary_command_reg_q[CMD_SERRE_BIT];
	assign parErr = (^gfxData) != parSync_q[1];

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			genPar_q <= 1'b0;
		end else begin
			genPar_q <= ^gfxData;
		end
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			perr_n_q <= 1'b1;
		end else begin
			perr_n_q <= !(perrOn && gfxDataPhase && parErr);
		end
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			serr_n_q <= 1'b1;
		end else begin
			serr_n_q <= !((bridge_control_q[BC_SERR_BIT] && serreOn && !gserrSync_q[1])
				|| (perrOn && serreOn && gfxAddrPhase && parErr));
		end
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			dac_q <= 1'b0;
		end else begin
			dac_q <= 1'b0;
		end
	end

	assign gfxParityOut = genPar_q;
	assign graphics_parity_error_out_n = perr_n_q;
	assign primarySerr_n = serr_n_q;
	assign dualAddrCycleEn = dac_q;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	sequence hiCycle_s;
		cycValid && above4g;
	endsequence

	vga_mem_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		cycValid && !above4g && !cycIn.isIo && vgaMem && vgaOn |=> routeOut.target == TGT_GRAPHICS)
		else $error("vga memory not routed to graphics");
	vga_io_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		cycValid && !above4g && cycIn.isIo && vgaIo && vgaOn |=> routeOut.target == TGT_GRAPHICS)
		else $error("vga io not routed to graphics");
	vga_off_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		cycValid && !above4g && !cycIn.isIo && vgaMem && !vgaOn && !memWin && !pfWin
		|=> routeOut.target == TGT_PCI)
		else $error("vga memory with routing off not on pci");
	isa_filter_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		cycValid && !above4g && cycIn.isIo && isaOn && isaAlias && !(vgaOn && vgaIo)
		|=> routeOut.target == TGT_PCI)
		else $error("isa alias not sent to pci");
	io_window_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		cycValid && !above4g && cycIn.isIo && ioWin && !isaOn |=> routeOut.target == TGT_GRAPHICS)
		else $error("io window cycle not on graphics");
	serr_fwd_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		!primarySerr_n |-> $past(serreOn))
		else $error("serr without secondary enable");
	perr_gate_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		!graphics_parity_error_out_n |-> $past(perrOn) && $past(gfxDataPhase))
		else $error("parity error reported while disabled");
	high_term_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		hiCycle_s ##1 1'b1 |-> routeValid && routeOut.target == TGT_LOCAL
		&& (routeOut.zeroRead != routeOut.dropWrite))
		else $error("high cycle not terminated locally");
	high_write_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		hiCycle_s and cycIn.isWrite |=> routeOut.dropWrite && !routeOut.zeroRead)
		else $error("high write not discarded");
	no_dac_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		!dualAddrCycleEn)
		else $error("dual address cycle enabled");
endmodule

//--- verification/hcar_gfx_agent.sv
// graphics port agent model on the far side of the router
`timescale 1ns/1ps
module hcar_gfx_agent
	import hcar_pkg::*;
(
	// clock and reset
	input wire logic core_clk,
	input wire logic sys_rst,
	// bench control
	input wire logic xferGo,
	input wire logic xferAddr,
	input wire logic xferBad,
	input wire logic [31:0] xferData,
	input wire logic sysErr,
	// graphics port lines
	output logic [31:0] gfxData,
	output logic gfxParityIn,
	output logic gfxAddrPhase,
	output logic gfxDataPhase,
	output logic graphics_system_error_in_n
);
	// ----------------------------------------
	// data, parity and phase lines
	// ----------------------------------------
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			gfxData <= 32'h00000001;
			gfxParityIn <= 1'b1;
			gfxAddrPhase <= 1'b0;
			gfxDataPhase <= 1'b0;
		end else if (xferGo) begin
			gfxData <= xferData;
			gfxParityIn <= (^xferData) ^ xferBad;
			gfxAddrPhase <= xferAddr;
			gfxDataPhase <= ~xferAddr;
		end else begin
			// released bus keeps moving so stale data never looks valid
			gfxData <= ~gfxData;
			gfxParityIn <= ^gfxData;
			gfxAddrPhase <= 1'b0;
			gfxDataPhase <= 1'b0;
		end
	end
	// ----------------------------------------
	// pulled-up system error line
	// ----------------------------------------
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			graphics_system_error_in_n <= 1'b1;
		end else begin
			graphics_system_error_in_n <= ~sysErr;
		end
	end
endmodule

//--- verification/test_host_cycle_address_router.sv
// self-checking bench of the host cycle address router
`timescale 1ns/1ps
module test_host_cycle_address_router
	import hcar_pkg::*;
;
	localparam logic MEM = 1'b0;
	localparam logic IO = 1'b1;
	localparam logic RD = 1'b0;
	localparam logic WR = 1'b1;
	logic core_clk, sys_rst, regWrite, regRead, cycValid, routeValid;
	logic [7:0] regAddr;
	logic [15:0] regWrData, regRdData;
	hcar_cycle_t cycIn;
	hcar_route_t routeOut;
	logic [31:0] gfxData, xferData;
	logic gfxParityIn, gfxAddrPhase, gfxDataPhase, graphics_system_error_in_n;
	logic gfxParityOut, graphics_parity_error_out_n, primarySerr_n, dualAddrCycleEn;
	logic xferGo, xferAddr, xferBad, sysErr;
	int mismatches, checks_done;

	hcar_router hcar_router_i (.core_clk, .sys_rst, .regAddr, .regWrData, .regWrite, .regRead, .regRdData,
		.cycValid, .cycIn, .routeValid, .routeOut, .gfxData, .gfxParityIn, .gfxAddrPhase, .gfxDataPhase,
		.graphics_system_error_in_n, .gfxParityOut, .graphics_parity_error_out_n, .primarySerr_n,
		.dualAddrCycleEn);
	hcar_gfx_agent hcar_gfx_agent_i (.core_clk, .sys_rst, .xferGo, .xferAddr, .xferBad, .xferData, .sysErr,
		.gfxData, .gfxParityIn, .gfxAddrPhase, .gfxDataPhase, .graphics_system_error_in_n);

	// ----------------------------------------
	// reporting and comparison
	// ----------------------------------------
	task automatic fail(input string m);
		mismatches++;
		$display("ERROR at %0t: %s", $time, m);
	endtask
	task automatic conclude();
		$display("checks %0d, mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chkReg(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) fail($sformatf("register read %h, expected %h", got, exp));
	endtask
	task automatic chkBit(input logic got, input logic exp, input string what);
		checks_done++;
		if (got !== exp) fail($sformatf("%s is %b, expected %b", what, got, exp));
	endtask
	task automatic chkRoute(input hcar_route_t exp, input logic [35:0] a);
		checks_done++;
		if (routeOut !== exp) fail($sformatf("route of %h is %h, expected %h", a, routeOut, exp));
	endtask
	// ----------------------------------------
	// bus tasks
	// ----------------------------------------
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge core_clk);
		regAddr <= a;
		regWrData <= d;
		regWrite <= 1'b1;
		@(posedge core_clk);
		regWrite <= 1'b0;
	endtask
	task automatic rdChk(input logic [7:0] a, input logic [15:0] e);
		@(posedge core_clk);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge core_clk);
		regRead <= 1'b0;
		@(negedge core_clk);
		chkReg(regRdData, e);
	endtask
	task automatic rt(input logic io, input logic w, input logic [35:0] a, input hcar_target_t t);
		int n;
		@(posedge core_clk);
		cycValid <= 1'b1;
		cycIn <= '{io, w, a};
		@(posedge core_clk);
		cycValid <= 1'b0;
		@(negedge core_clk);
		for (n = 0; n < 4 && routeValid !== 1'b1; n++) @(negedge core_clk);
		if (n == 4) begin
			fail("no route answer");
			conclude();
		end
		chkRoute('{t, (t == TGT_LOCAL) && !w, (t == TGT_LOCAL) && w}, a);
	endtask
	task automatic watch(output logic sS, output logic sP);
		sS = 1'b0;
		sP = 1'b0;
		repeat (10) begin
			@(negedge core_clk);
			if (primarySerr_n === 1'b0) sS = 1'b1;
			if (graphics_parity_error_out_n === 1'b0) sP = 1'b1;
		end
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_regs();
		rdChk(OFS_BRIDGE_CONTROL, RST_BRIDGE_CONTROL);
		rdChk(OFS_MEM_BASE, RST_MEM_BASE);
		rdChk(OFS_MEM_LIMIT, RST_MEM_LIMIT);
		rdChk(8'hff, 16'h0000);
		wr(OFS_BRIDGE_CONTROL, 16'hffff);
		rdChk(OFS_BRIDGE_CONTROL, 16'h000f);
		chkBit(dualAddrCycleEn, 1'b0, "dual address enable");
		$display("register test done");
	endtask
	task automatic t_vga();
		wr(OFS_BRIDGE_CONTROL, 16'h000c);
		rt(MEM, RD, 36'h0000a0000, TGT_GRAPHICS);
		rt(MEM, WR, 36'h0000bffff, TGT_GRAPHICS);
		rt(IO, RD, 36'h0000003b0, TGT_GRAPHICS);
		rt(IO, WR, 36'h0000003bb, TGT_GRAPHICS);
		rt(IO, RD, 36'h0000003c0, TGT_GRAPHICS);
		rt(IO, RD, 36'h0000003df, TGT_GRAPHICS);
		rt(IO, RD, 36'h00000ffb0, TGT_GRAPHICS);
		rt(IO, RD, 36'h0000003bc, TGT_PCI);
		rt(IO, RD, 36'h0000003e0, TGT_PCI);
		wr(OFS_BRIDGE_CONTROL, 16'h0000);
		rt(MEM, RD, 36'h0000a0000, TGT_PCI);
		rt(IO, RD, 36'h0000003c0, TGT_PCI);
		$display("vga routing test done");
	endtask
	task automatic t_io();
		wr(OFS_IO_BASE, 16'h0020);
		wr(OFS_IO_LIMIT, 16'h0030);
		rt(IO, RD, 36'h000002000, TGT_GRAPHICS);
		rt(IO, WR, 36'h000002100, TGT_GRAPHICS);
		rt(IO, RD, 36'h000003fff, TGT_GRAPHICS);
		rt(IO, RD, 36'h0000023c0, TGT_GRAPHICS);
		rt(IO, RD, 36'h000004000, TGT_PCI);
		rt(IO, RD, 36'h000001fff, TGT_PCI);
		wr(OFS_BRIDGE_CONTROL, 16'h0004);
		rt(IO, RD, 36'h000002000, TGT_GRAPHICS);
		rt(IO, RD, 36'h0000020ff, TGT_GRAPHICS);
		rt(IO, RD, 36'h000002100, TGT_PCI);
		rt(IO, WR, 36'h0000022ff, TGT_PCI);
		rt(IO, RD, 36'h000003fff, TGT_PCI);
		wr(OFS_BRIDGE_CONTROL, 16'h0000);
		$display("io window test done");
	endtask
	task automatic t_mem();
		wr(OFS_MEM_BASE, 16'h1000);
		wr(OFS_MEM_LIMIT, 16'h1010);
		rt(MEM, RD, 36'h010000000, TGT_GRAPHICS);
		rt(MEM, WR, 36'h0101fffff, TGT_GRAPHICS);
		rt(MEM, RD, 36'h010200000, TGT_PCI);
		rt(MEM, RD, 36'h00fffffff, TGT_PCI);
		wr(OFS_PF_BASE, 16'h0000);
		wr(OFS_PF_LIMIT, 16'h0000);
		rt(MEM, RD, 36'h0000a0000, TGT_GRAPHICS);
		wr(OFS_PF_BASE, RST_MEM_BASE);
		wr(OFS_HOLE_CTRL, 16'h0002);
		rt(MEM, RD, 36'h010000000, TGT_PCI);
		$display("memory window test done");
	endtask
	task automatic t_dram();
		wr(OFS_TOP_DRAM, 16'h0010);
		wr(OFS_HOLE_CTRL, 16'h0000);
		rt(MEM, RD, 36'h001000000, TGT_MEMORY);
		rt(MEM, RD, 36'h001100000, TGT_PCI);
		rt(MEM, WR, 36'h000080000, TGT_MEMORY);
		rt(MEM, RD, 36'h0000b0000, TGT_PCI);
		rt(MEM, RD, 36'h0000c0000, TGT_PCI);
		wr(OFS_HOLE_CTRL, 16'h0001);
		rt(MEM, RD, 36'h000080000, TGT_PCI);
		rt(MEM, RD, 36'h00007ffff, TGT_MEMORY);
		wr(OFS_SEG_READ, 16'h0001);
		wr(OFS_SEG_WRITE, 16'h1000);
		rt(MEM, RD, 36'h0000c0000, TGT_MEMORY);
		rt(MEM, WR, 36'h0000c0000, TGT_PCI);
		rt(MEM, RD, 36'h0000c4000, TGT_PCI);
		rt(MEM, WR, 36'h0000f0000, TGT_MEMORY);
		rt(MEM, RD, 36'h0000f0000, TGT_PCI);
		rt(MEM, WR, 36'h0000ffff0, TGT_MEMORY);
		$display("main memory test done");
	endtask
	task automatic t_high();
		wr(OFS_BRIDGE_CONTROL, 16'h0008);
		rt(MEM, RD, 36'h1000a0000, TGT_LOCAL);
		rt(MEM, WR, 36'hfffffffff, TGT_LOCAL);
		rt(MEM, RD, 36'h100000000, TGT_LOCAL);
		rdChk(OFS_STATUS, 16'h0003);
		wr(OFS_BRIDGE_CONTROL, 16'h0000);
		$display("above 4 GB test done");
	endtask
	task automatic t_err();
		logic sS, sP;
		for (int i = 0; i < 12; i++) begin
			wr(OFS_BRIDGE_CONTROL, (16'(i[0]) << BC_SERR_BIT) | (16'(i[0]) << BC_PERR_BIT));
			wr(OFS_SEC_COMMAND, 16'(i[1]) << CMD_SERRE_BIT);
			@(posedge core_clk);
			sysErr <= (i < 4);
			xferGo <= (i >= 4);
			xferAddr <= i[2];
			xferBad <= 1'b1;
			xferData <= i[0] ? 32'h00000007 : 32'h00000003;
			watch(sS, sP);
			if (i < 4) begin
				chkBit(sS, i == 3, "forwarded system error");
			end else begin
				chkBit(gfxParityOut, ^xferData, "generated parity");
				chkBit(sP, i[0] && !i[2], "parity error report");
				chkBit(sS, i[0] && i[1] && i[2], "address parity system error");
			end
			@(posedge core_clk);
			sysErr <= 1'b0;
			xferGo <= 1'b0;
			repeat (8) @(posedge core_clk);
		end
		$display("error forwarding test done");
	endtask
	// ----------------------------------------
	// clock, reset and sequence
	// ----------------------------------------
	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end
	initial begin
		sys_rst = 1'b1;
		regAddr = 8'h00;
		regWrData = 16'h0000;
		regWrite = 1'b0;
		regRead = 1'b0;
		cycValid = 1'b0;
		cycIn = '0;
		xferGo = 1'b0;
		xferAddr = 1'b0;
		xferBad = 1'b0;
		xferData = 32'h00000000;
		sysErr = 1'b0;
		mismatches = 0;
		checks_done = 0;
		repeat (4) @(posedge core_clk);
		sys_rst <= 1'b0;
		t_regs();
		t_vga();
		t_io();
		t_mem();
		t_dram();
		t_high();
		t_err();
		conclude();
	end
endmodule
